//--- serial_channel_pkg.sv
package serial_channel_pkg;
    // register byte addresses
    localparam logic [15:0] ADDR_STATUS_CLKSEL = 16'h2004;
    localparam logic [15:0] ADDR_COMMAND = 16'h2008;
    localparam logic [15:0] ADDR_RX_FIFO = 16'h200C;
    localparam logic [15:0] ADDR_CONFIG = 16'h2040;
    localparam logic [15:0] ADDR_ALARM = 16'h2044;
    localparam logic [15:0] ADDR_RELEASE = 16'h2048;
    // status bit positions, msb-first numbering mapped to lsb index 15-n
    localparam int ST_RX_BREAK = 15;
    localparam int ST_FRAMING = 14;
    localparam int ST_PARITY = 13;
    localparam int ST_OVERRUN = 12;
    localparam int ST_TX_IDLE = 11;
    localparam int ST_UNDERRUN = 11;
    localparam int ST_TX_AEMPTY = 10;
    localparam int ST_RX_AFULL = 9;
    localparam int ST_RX_PRESENT = 8;
    localparam int ST_CARRIER = 7;
    // command fields (msb-first 9:11, 12:13, 14:15)
    localparam int CMD_MISC_LSB = 4;
    localparam int CMD_TX_LSB = 2;
    localparam int CMD_RX_LSB = 0;
    localparam int CS_RX_LSB = 4;
    localparam int CS_TX_LSB = 0;
    localparam logic [3:0] CS_FIRST_INVALID = 4'hE;
    localparam logic [2:0] MISC_MODE_PTR = 3'h1;
    localparam logic [2:0] MISC_RESET_RX = 3'h2;
    localparam logic [2:0] MISC_RESET_TX = 3'h3;
    localparam logic [2:0] MISC_RESET_ERR = 3'h4;
    localparam logic [2:0] MISC_RESET_DBRK = 3'h5;
    localparam logic [2:0] MISC_START_BRK = 3'h6;
    localparam logic [2:0] MISC_STOP_BRK = 3'h7;
    localparam logic [1:0] EN_CODE = 2'h1;
    localparam logic [1:0] DIS_CODE = 2'h2;
    localparam logic [1:0] PM_MULTIDROP = 2'h3;
    localparam logic [1:0] CM_ECHO = 2'h1;
    localparam logic [1:0] CM_LOCAL_LOOP = 2'h2;
    localparam logic [1:0] CM_REMOTE_LOOP = 2'h3;
    // receive fifo: 512 bytes held as 128 words
    localparam int RX_DEPTH = 128;
    localparam logic [7:0] RX_FULL_WORDS = 8'h80;
    localparam int DBRK_READ_BIT = 31;

    typedef struct packed {
        logic sampleMode;
        logic codecMode;
        logic [1:0] parityMode;
        logic parityType;
        logic [1:0] channelMode;
    } mode_cfg_t;

    typedef struct packed {
        logic rxWordValid;
        logic [31:0] rxWord;
        logic rxCharActive;
        logic frameSync;
        logic txShiftEmpty;
        logic txCharActive;
        logic [8:0] txFifoCount;
        logic codecReady;
        logic carrierLost;
        logic rxBreak;
        logic rxFraming;
        logic rxParity;
        logic deltaBreak;
    } engine_status_t;

    typedef struct packed {
        logic txEnable;
        logic rxEnable;
        logic rxActive;
        logic rxSearchStart;
        logic txBreak;
        logic txAddressChar;
        logic modePtrFirst;
        logic [3:0] rxClockSource;
        logic [3:0] txClockSource;
    } engine_ctrl_t;
endpackage

//--- serial_channel_command_status.sv
`timescale 1ns/10ps
// What this block does
// - status bit 8 low after carrier loss
// - sample overrun: full fifo plus waiting sample
// - sample underrun on sync with tx empty
// - underrun cleared only by error reset
// - tx almost empty follows alarm level
// - rx almost full with release hysteresis
// - rx data present while fifo nonempty
// - clock source fields, invalid codes ignored
// - command 001 resets mode pointer
// - command 010 resets receiver and fifo
// - command 011 resets transmitter, keeps underrun
// - command 100 clears error flags
// - command 101 clears delta break in character mode
// - command 110 starts break after character
// - break needs tx enabled, not sample mode
// - command 111 ends break, resumes data
// - tx enable sets idle flags in character mode
// - codec underrun needs codec ready
// - tx disable waits for character end
// - rx enable searches start bit except in multidrop
// - rx disable, sample mode finishes sample
// - multidrop when parity mode is 11
// - reading rx buffer pops fifo
module serial_channel_command_status (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // serial engine
    input serial_channel_pkg::engine_status_t engStat,
    output serial_channel_pkg::engine_ctrl_t engCtrl
);
    import serial_channel_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    mode_cfg_t cfg_q;
    logic [8:0] txAlarm_q;
    logic [9:0] rxAlarm_q;
    logic [9:0] rxRelease_q;
    logic [3:0] rxClk_q, txClk_q;
    logic txEn_q, txDisPend_q, rxEn_q, rxDisPend_q;
    logic breakReq_q, txBreak_q, modePtr_q, rxSearch_q;
    logic txIdle_q, txAEmpty_q, rxAFull_q;
    logic ovr_q, udr_q, brk_q, fe_q, pe_q, carrierErr_q, dBrk_q;
    logic [31:0] rxMem [RX_DEPTH];
    logic [6:0] rxWrPtr_q, rxRdPtr_q;
    logic [7:0] rxCount_q;
    logic [31:0] pend_q;
    logic pendValid_q;
    logic [31:0] rdata_q;

    // command decode: one write gives one pulse per field
    logic cmdWr;
    logic [2:0] misc;
    logic [1:0] txCmd, rxCmd;
    assign cmdWr = regWr && regAddr == ADDR_COMMAND;
    assign misc = cmdWr ? regWdata[CMD_MISC_LSB+:3] : 3'h0;
    assign txCmd = cmdWr ? regWdata[CMD_TX_LSB+:2] : 2'h0;
    assign rxCmd = cmdWr ? regWdata[CMD_RX_LSB+:2] : 2'h0;

    logic resetRx, resetTx, resetErr, multidrop, echoRemote, txOn, txEmpty;
    assign resetRx = misc == MISC_RESET_RX;
    assign resetTx = misc == MISC_RESET_TX;
    assign resetErr = misc == MISC_RESET_ERR;
    assign multidrop = cfg_q.parityMode == PM_MULTIDROP;
    assign echoRemote = cfg_q.channelMode == CM_ECHO || cfg_q.channelMode == CM_REMOTE_LOOP;
    assign txOn = txEn_q && !txDisPend_q;
    assign txEmpty = engStat.txShiftEmpty && engStat.txFifoCount == 9'h000;

    // configuration and alarm registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_q <= '0;
            txAlarm_q <= 9'h000;
            rxAlarm_q <= 10'h000;
            rxRelease_q <= 10'h000;
        end else if (regWr) begin
            if (regAddr == ADDR_CONFIG) cfg_q <= regWdata[6:0];
            if (regAddr == ADDR_ALARM) begin
                txAlarm_q <= regWdata[8:0];
                rxAlarm_q <= regWdata[25:16];
            end
            if (regAddr == ADDR_RELEASE) rxRelease_q <= regWdata[9:0];
        end
    end

    // clock source select, invalid codes leave the field alone
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rxClk_q <= 4'h0;
            txClk_q <= 4'h0;
        end else if (regWr && regAddr == ADDR_STATUS_CLKSEL) begin
            if (regWdata[CS_RX_LSB+:4] < CS_FIRST_INVALID) rxClk_q <= regWdata[CS_RX_LSB+:4];
            if (regWdata[CS_TX_LSB+:4] < CS_FIRST_INVALID) txClk_q <= regWdata[CS_TX_LSB+:4];
        end
    end

    // one-cycle pulses to the engine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modePtr_q <= 1'b0;
            rxSearch_q <= 1'b0;
        end else begin
            modePtr_q <= misc == MISC_MODE_PTR;
            rxSearch_q <= rxCmd == EN_CODE && !rxEn_q && !multidrop && !resetRx;
        end
    end

    // transmitter enable, disable waits for the character in flight
    always_ff @(posedge clk) begin
        if (sys_rst || resetTx) begin
            txEn_q <= 1'b0;
            txDisPend_q <= 1'b0;
        end else if (txCmd == EN_CODE) begin
            txEn_q <= 1'b1;
            txDisPend_q <= 1'b0;
        end else if (txDisPend_q && !engStat.txCharActive) begin
            txEn_q <= 1'b0;
            txDisPend_q <= 1'b0;
        end else if (txCmd == DIS_CODE && txEn_q) begin
            txDisPend_q <= 1'b1;
        end
    end

    // break request and line hold
    always_ff @(posedge clk) begin
        if (sys_rst || resetTx) begin
            breakReq_q <= 1'b0;
            txBreak_q <= 1'b0;
        end else begin
            if (misc == MISC_STOP_BRK) breakReq_q <= 1'b0;
            else if (misc == MISC_START_BRK && txEn_q && !cfg_q.sampleMode) breakReq_q <= 1'b1;
            txBreak_q <= breakReq_q && misc != MISC_STOP_BRK && (txBreak_q || !engStat.txCharActive);
        end
    end

    // receiver enable, sample mode finishes the sample in progress
    always_ff @(posedge clk) begin
        if (sys_rst || resetRx) begin
            rxEn_q <= 1'b0;
            rxDisPend_q <= 1'b0;
        end else if (rxCmd == EN_CODE) begin
            rxEn_q <= 1'b1;
            rxDisPend_q <= 1'b0;
        end else if (rxCmd == DIS_CODE && rxEn_q) begin
            if (cfg_q.sampleMode && engStat.rxCharActive) rxDisPend_q <= 1'b1;
            else rxEn_q <= 1'b0;
        end else if (rxDisPend_q && !engStat.rxCharActive) begin
            rxEn_q <= 1'b0;
            rxDisPend_q <= 1'b0;
        end
    end

    logic rxActive;
    assign rxActive = rxEn_q || multidrop || cfg_q.channelMode == CM_LOCAL_LOOP;

    // receive fifo push, pop and the waiting shift-register sample
    logic rxFull, arrive, drain, direct, push, pop, overrunEv;
    logic [31:0] headWord;
    assign rxFull = rxCount_q == RX_FULL_WORDS;
    assign arrive = engStat.rxWordValid && rxActive;
    assign drain = pendValid_q && !rxFull;
    assign direct = arrive && !pendValid_q && !rxFull;
    assign push = drain || direct;
    assign pop = regRd && regAddr == ADDR_RX_FIFO && rxCount_q != 8'h00;
    assign overrunEv = arrive && rxFull && pendValid_q;
    assign headWord = rxMem[rxRdPtr_q];

    always_ff @(posedge clk) begin
        if (push) rxMem[rxWrPtr_q] <= drain ? pend_q : engStat.rxWord;
    end

    always_ff @(posedge clk) begin
        if (sys_rst || resetRx) begin
            rxWrPtr_q <= 7'h00;
            rxRdPtr_q <= 7'h00;
            rxCount_q <= 8'h00;
            pendValid_q <= 1'b0;
            pend_q <= 32'h00000000;
        end else begin
            if (push) rxWrPtr_q <= rxWrPtr_q + 7'h01;
            if (pop) rxRdPtr_q <= rxRdPtr_q + 7'h01;
            rxCount_q <= rxCount_q + {7'h00, push} - {7'h00, pop};
            if (arrive && !direct) begin
                pend_q <= engStat.rxWord;
                pendValid_q <= 1'b1;
            end else if (drain) begin
                pendValid_q <= 1'b0;
            end
        end
    end

    // fifo level flags
    logic [9:0] rxBytes;
    assign rxBytes = {rxCount_q, 2'b00};
    always_ff @(posedge clk) begin
        if (sys_rst || resetRx) begin
            rxAFull_q <= 1'b0;
        end else if (rxBytes > rxAlarm_q) begin
            rxAFull_q <= 1'b1;
        end else if (rxBytes <= rxRelease_q) begin
            rxAFull_q <= 1'b0;
        end
    end

    logic txAEmptyGate;
    assign txAEmptyGate = cfg_q.sampleMode ? (txOn || !echoRemote) : txOn;
    always_ff @(posedge clk) begin
        if (sys_rst || resetTx) begin
            txAEmpty_q <= 1'b0;
        end else begin
            txAEmpty_q <= txAEmptyGate && !(txCmd == DIS_CODE && !(cfg_q.sampleMode && !echoRemote))
                && engStat.txFifoCount <= txAlarm_q;
        end
    end

    // transmitter idle flag, character mode
    always_ff @(posedge clk) begin
        if (sys_rst || resetTx || txCmd == DIS_CODE) begin
            txIdle_q <= 1'b0;
        end else if (txCmd == EN_CODE && !cfg_q.sampleMode) begin
            txIdle_q <= 1'b1;
        end else if (txOn && !cfg_q.sampleMode) begin
            txIdle_q <= txEmpty;
        end
    end

    // sticky error flags, a set in the clearing cycle wins
    logic udrEv, charMode;
    assign charMode = !cfg_q.sampleMode;
    assign udrEv = cfg_q.sampleMode && txOn && engStat.frameSync && txEmpty
        && (!cfg_q.codecMode || engStat.codecReady);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ovr_q <= 1'b0;
            udr_q <= 1'b0;
            brk_q <= 1'b0;
            fe_q <= 1'b0;
            pe_q <= 1'b0;
            carrierErr_q <= 1'b0;
            dBrk_q <= 1'b0;
        end else begin
            ovr_q <= overrunEv || (ovr_q && !resetErr);
            udr_q <= udrEv || (udr_q && !resetErr);
            brk_q <= (charMode && engStat.rxBreak) || (brk_q && !resetErr);
            fe_q <= (charMode && engStat.rxFraming) || (fe_q && !resetErr);
            pe_q <= (charMode && engStat.rxParity) || (pe_q && !resetErr);
            carrierErr_q <= (charMode && engStat.carrierLost) || (carrierErr_q && !resetErr);
            dBrk_q <= (charMode && engStat.deltaBreak)
                || (dBrk_q && !(misc == MISC_RESET_DBRK && charMode));
        end
    end

    // status word for the current mode
    logic [15:0] status;
    always_comb begin
        status = 16'h0000;
        status[ST_OVERRUN] = ovr_q;
        status[ST_TX_AEMPTY] = txAEmpty_q;
        status[ST_RX_AFULL] = rxAFull_q;
        status[ST_RX_PRESENT] = rxCount_q != 8'h00;
        if (cfg_q.sampleMode) begin
            status[ST_UNDERRUN] = udr_q;
        end else begin
            status[ST_RX_BREAK] = brk_q;
            status[ST_FRAMING] = fe_q;
            status[ST_PARITY] = pe_q;
            status[ST_TX_IDLE] = txIdle_q;
            status[ST_CARRIER] = !carrierErr_q;
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= 32'h00000000;
            if (regRd) begin
                unique case (regAddr)
                    ADDR_STATUS_CLKSEL: rdata_q <= {16'h0000, status};
                    ADDR_RX_FIFO: rdata_q <= pop ? headWord : 32'h00000000;
                    ADDR_CONFIG: begin
                        rdata_q <= {25'h0000000, cfg_q};
                        rdata_q[DBRK_READ_BIT] <= dBrk_q;
                    end
                    ADDR_ALARM: rdata_q <= {6'h00, rxAlarm_q, 7'h00, txAlarm_q};
                    ADDR_RELEASE: rdata_q <= {22'h000000, rxRelease_q};
                    default: rdata_q <= 32'h00000000;
                endcase
            end
        end
    end
    assign regRdata = rdata_q;

    // engine controls
    always_comb begin
        engCtrl.txEnable = txEn_q;
        engCtrl.rxEnable = rxEn_q;
        engCtrl.rxActive = rxActive;
        engCtrl.rxSearchStart = rxSearch_q;
        engCtrl.txBreak = txBreak_q;
        engCtrl.txAddressChar = multidrop && cfg_q.parityType;
        engCtrl.modePtrFirst = modePtr_q;
        engCtrl.rxClockSource = rxClk_q;
        engCtrl.txClockSource = txClk_q;
    end

    // checks
    a_overrun_sets: assert property (overrunEv |=> ovr_q) else $error("overrun not flagged");
    a_underrun_sets: assert property (udrEv |=> status[ST_UNDERRUN]) else $error("underrun not flagged");
    a_underrun_holds: assert property (udr_q && !resetErr |=> udr_q) else $error("underrun lost");
    a_afull_hyst: assert property (rxAFull_q && rxBytes > rxRelease_q && !resetRx |=> rxAFull_q)
        else $error("almost full dropped early");
    a_present_tracks: assert property (pop && rxCount_q == 8'h01 && !push |=> !status[ST_RX_PRESENT])
        else $error("data present after last pop");
    a_clksel_guard: assert property (regWr && regAddr == ADDR_STATUS_CLKSEL
        && regWdata[CS_RX_LSB+:4] >= CS_FIRST_INVALID |=> $stable(rxClk_q))
        else $error("invalid clock code taken");
    a_modeptr_pulse: assert property (engCtrl.modePtrFirst |-> $past(misc) == MISC_MODE_PTR)
        else $error("stray mode pointer pulse");
    a_rx_reset: assert property (resetRx |=> rxCount_q == 8'h00 && !rxAFull_q && !rxEn_q)
        else $error("receiver reset incomplete");
    a_break_gate: assert property ($rose(breakReq_q) |-> $past(txEn_q && !cfg_q.sampleMode))
        else $error("break accepted while not allowed");
    a_pop_data: assert property (pop |=> regRdata == $past(headWord)) else $error("wrong fifo data");
    a_tx_disable: assert property (txDisPend_q && engStat.txCharActive && !resetTx |=> txEn_q)
        else $error("tx stopped mid character");
    c_overrun: cover property (overrunEv);
    c_underrun_clear: cover property (udr_q ##1 resetErr ##1 !udr_q);
    c_break_cycle: cover property (txBreak_q ##[1:20] !txBreak_q);
endmodule

//--- serial_engine_model.sv
`timescale 1ns/10ps
module serial_engine_model (
    // clock
    input wire logic clk,
    // requests from the bench
    input wire logic pushWord,
    input wire logic [31:0] pushData,
    input wire logic syncReq,
    input wire logic carrierReq,
    input wire logic [8:0] txBytes,
    // engine status toward the block
    output serial_channel_pkg::engine_status_t engStat
);
    import serial_channel_pkg::*;
    // event pulses and levels, registered once per edge
    logic rxValid_q = 1'b0;
    logic [31:0] rxWord_q = 32'h0000_0000;
    logic sync_q = 1'b0;
    logic carrier_q = 1'b0;
    logic [8:0] txCount_q = 9'h000;
    // one-cycle event pulses and the tx byte count level; rx data scrambled while no word is offered
    always @(posedge clk) begin
        rxValid_q <= pushWord;
        rxWord_q <= pushWord ? pushData : ~rxWord_q;
        sync_q <= syncReq;
        carrier_q <= carrierReq;
        txCount_q <= txBytes;
    end
    // idle engine: shifter empty, codec ready, one driver for the whole struct
    always_comb begin
        engStat = '0;
        engStat.txShiftEmpty = 1'b1;
        engStat.codecReady = 1'b1;
        engStat.rxWordValid = rxValid_q;
        engStat.rxWord = rxWord_q;
        engStat.frameSync = sync_q;
        engStat.carrierLost = carrier_q;
        engStat.txFifoCount = txCount_q;
    end
endmodule

//--- serial_channel_command_status_bench.sv
`timescale 1ns/10ps
module serial_channel_command_status_bench;
    import serial_channel_pkg::*;
    // design port signals
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] regAddr = 16'h0000;
    logic [31:0] regWdata = 32'h0000_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    engine_status_t engStat;
    engine_ctrl_t engCtrl;
    // engine model requests
    logic pushWord = 1'b0;
    logic [31:0] pushData = 32'h0000_0000;
    logic syncReq = 1'b0;
    logic carrierReq = 1'b0;
    logic [8:0] txBytes = 9'h000;
    // scoreboard state
    logic [31:0] expQ[$];
    logic [31:0] fifoQ[$];
    logic [31:0] expWord;
    logic rdLate = 1'b0;
    int errTotal = 0;
    int samplesChecked = 0;
    integer seed = 32'h5196F087;

    serial_channel_command_status dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .engStat(engStat), .engCtrl(engCtrl));
    serial_engine_model model (.clk(clk), .pushWord(pushWord), .pushData(pushData), .syncReq(syncReq),
        .carrierReq(carrierReq), .txBytes(txBytes), .engStat(engStat));

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic fail(input string msg);
        errTotal++;
        $display("[FAIL] t=%0t %s", $time, msg);
    endtask

    task automatic stopTest();
        $display("comparisons %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic checkVal(input logic [31:0] got, input logic [31:0] exp, input string what);
        samplesChecked++;
        if (got !== exp) begin
            fail($sformatf("%s got %h exp %h", what, got, exp));
        end
    endtask

    task automatic endTest(input string name);
        $display("test %s done", name);
    endtask

    // one-cycle write strobe, returns at the sampling edge
    task automatic regWrite(input logic [15:0] addr, input logic [31:0] data);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= addr;
        regWdata <= data;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // one-cycle read strobe; the expected word goes to the queue
    task automatic regRead(input logic [15:0] addr, input logic [31:0] exp);
        @(posedge clk);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= addr;
        expQ.push_back(exp);
        @(posedge clk);
        regRd <= 1'b0;
    endtask

    // engine event: 0 word, 1 frame sync, 2 carrier loss
    task automatic engEvent(input int kind);
        logic [31:0] w;
        w = $random(seed);
        @(posedge clk);
        pushWord <= (kind == 0);
        pushData <= w;
        syncReq <= (kind == 1);
        carrierReq <= (kind == 2);
        if (kind == 0) begin
            fifoQ.push_back(w);
        end
        @(posedge clk);
        pushWord <= 1'b0;
        syncReq <= 1'b0;
        carrierReq <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic popWord();
        regRead(ADDR_RX_FIFO, fifoQ.pop_front());
    endtask

    // bounded wait on the break line
    task automatic waitBreak(input logic want);
        int n;
        n = 0;
        while (engCtrl.txBreak !== want && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        samplesChecked++;
        if (engCtrl.txBreak !== want) begin
            fail("break line level");
            stopTest();
        end
    endtask

    // read data compared in the cycle after the strobe
    always @(posedge clk) begin
        rdLate <= regRd;
    end
    always @(negedge clk) begin
        if (rdLate) begin
            samplesChecked++;
            if (expQ.size() == 0) begin
                fail("read data without request");
            end else begin
                expWord = expQ.pop_front();
                if (regRdata !== expWord) begin
                    fail($sformatf("read got %h exp %h", regRdata, expWord));
                end
            end
        end
    end

    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        checkVal(32'(engCtrl), 32'h0, "ctrl after reset");
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0080);
        regRead(16'h1000, 32'h0);
        regRead(ADDR_RX_FIFO, 32'h0);
        endTest("reset");
        regWrite(ADDR_STATUS_CLKSEL, 32'h0000_005A);
        regWrite(ADDR_STATUS_CLKSEL, 32'h0000_00EF);
        #1;
        checkVal({24'h0, engCtrl.rxClockSource, engCtrl.txClockSource}, 32'h5A, "clock select");
        regWrite(ADDR_STATUS_CLKSEL, 32'h0000_00D0);
        #1;
        checkVal({24'h0, engCtrl.rxClockSource, engCtrl.txClockSource}, 32'hD0, "clock select max");
        endTest("clock select");
        regWrite(ADDR_COMMAND, 32'h0000_0001);
        #1;
        checkVal({30'h0, engCtrl.rxEnable, engCtrl.rxSearchStart}, 32'h3, "rx enable");
        @(posedge clk);
        #1;
        checkVal({31'h0, engCtrl.rxSearchStart}, 32'h0, "search pulse");
        regWrite(ADDR_ALARM, 32'h0004_0000);
        engEvent(0);
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0180);
        engEvent(0);
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0380);
        popWord();
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0380);
        popWord();
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0080);
        regRead(ADDR_RX_FIFO, 32'h0);
        endTest("rx fifo");
        engEvent(0);
        engEvent(0);
        regWrite(ADDR_COMMAND, 32'h0000_0020);
        fifoQ.delete();
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0080);
        regRead(ADDR_RX_FIFO, 32'h0);
        checkVal({31'h0, engCtrl.rxEnable}, 32'h0, "rx reset");
        endTest("rx reset");
        engEvent(2);
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0000);
        regWrite(ADDR_COMMAND, 32'h0000_0040);
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0080);
        regWrite(ADDR_COMMAND, 32'h0000_0010);
        #1;
        checkVal({31'h0, engCtrl.modePtrFirst}, 32'h1, "mode pointer");
        endTest("carrier and pointer");
        regWrite(ADDR_COMMAND, 32'h0000_0060);
        repeat (3) @(posedge clk);
        #1;
        checkVal({31'h0, engCtrl.txBreak}, 32'h0, "break while disabled");
        regWrite(ADDR_COMMAND, 32'h0000_0004);
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0C80);
        regWrite(ADDR_COMMAND, 32'h0000_0060);
        waitBreak(1'b1);
        regWrite(ADDR_COMMAND, 32'h0000_0070);
        waitBreak(1'b0);
        regWrite(ADDR_COMMAND, 32'h0000_0008);
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0080);
        checkVal({31'h0, engCtrl.txEnable}, 32'h0, "tx disable");
        endTest("transmitter");
        regWrite(ADDR_CONFIG, 32'h0000_0040); // sample mode is the top bit of the config field
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0400);
        regWrite(ADDR_COMMAND, 32'h0000_0004);
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0400);
        regWrite(ADDR_COMMAND, 32'h0000_0060);
        repeat (3) @(posedge clk);
        #1;
        checkVal({31'h0, engCtrl.txBreak}, 32'h0, "break in sample mode");
        engEvent(1);
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0C00);
        regWrite(ADDR_COMMAND, 32'h0000_0030);
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0C00);
        regWrite(ADDR_COMMAND, 32'h0000_0040);
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0400);
        txBytes <= 9'h005;
        regRead(ADDR_STATUS_CLKSEL, 32'h0000_0000);
        endTest("sample mode");
        regWrite(ADDR_CONFIG, 32'h0000_001C);
        #1;
        checkVal({30'h0, engCtrl.txAddressChar, engCtrl.rxActive}, 32'h3, "multidrop");
        regWrite(ADDR_COMMAND, 32'h0000_0001);
        #1;
        checkVal({30'h0, engCtrl.rxEnable, engCtrl.rxSearchStart}, 32'h2, "multidrop rx enable");
        regWrite(ADDR_COMMAND, 32'h0000_0002);
        #1;
        checkVal({30'h0, engCtrl.rxEnable, engCtrl.rxActive}, 32'h1, "multidrop rx disable");
        endTest("multidrop");
        repeat (3) @(posedge clk);
        checkVal(32'(expQ.size()), 32'h0, "reads left over");
        stopTest();
    end
endmodule
